// [hdl/tmfs_pkg.sv]
// constants shared by the test mode and fault supervisor
// assumes one 250 MHz clock and an Avalon-MM register bus
//
// What this block does
// - three test states; disabled keeps normal operation
// - isolated forces field contact/latch commands off
// - shared outputs keep operating in test states
// - test flag set when isolated or forcible
// - flagged shared input ignored unless own test
// - received GOOSE test flag is ignored
// - forcible unlocks configuration; others stay locked
// - indicator: flashing red isolated, flashing orange forcible
// - critical-failure output de-energized in test states
// - state changes only by command with setting access
// - last selected state kept across restart
// - activations logged; alarms listed for display
// - major fault de-energizes critical-failure output
// - major fault disables contact and shared outputs
// - major fault reverts protection operands, no events
// - major fault: solid red, out-of-service event
// - per-test status, major, minor, overall ORs
// - acknowledge removes entry from alarm list
// - majors always report; minors individually disableable
// - user-selected operand raises a major self-test
// - comm board fault is a major self-test
// - silent field unit: failsafe inputs, commands off
package tmfs_pkg;

	// =========================================================
	// sizes
	localparam int NUM_UNIT  = 4;   // field units on the process bus
	localparam int NUM_MAJOR = 4;   // major self-tests
	localparam int NUM_MINOR = 4;   // minor self-tests
	localparam int NUM_TEST  = 8;   // all self-tests
	localparam int NUM_OPND  = 8;   // selectable user logic operands
	localparam int NUM_SHARE = 4;   // shared outputs and inputs

	// =========================================================
	// test state codes
	localparam logic [1:0] TST_DISABLED = 2'h0;
	localparam logic [1:0] TST_ISOLATED = 2'h1;
	localparam logic [1:0] TST_FORCIBLE = 2'h2;

	// =========================================================
	// self-test bit positions in the alarm word
	localparam int BIT_COMM_BOARD = 0;  // comm_board_fault
	localparam int BIT_USER_SEL   = 1;  // user_selected_fault
	localparam int BIT_MAJOR_EXT  = 2;  // two further major inputs
	localparam int BIT_MINOR      = 4;  // first minor test

	// =========================================================
	// register byte offsets
	localparam logic [7:0] OFS_TEST_STATE = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_ALARM_LIST = 8'h08;
	localparam logic [7:0] OFS_ACK        = 8'h0C;
	localparam logic [7:0] OFS_MINOR_EN   = 8'h10;
	localparam logic [7:0] OFS_USER_SEL   = 8'h14;
	localparam logic [7:0] OFS_TEST_LIVE  = 8'h18;

	// =========================================================
	// status word fields
	localparam int STS_STATE  = 0;  // two bits
	localparam int STS_FLAG   = 2;
	localparam int STS_LOCK   = 3;
	localparam int STS_MAJOR  = 4;
	localparam int STS_MINOR  = 5;
	localparam int STS_ANY    = 6;
	localparam int STS_ACCESS = 7;

	// =========================================================
	// reset values
	localparam logic [NUM_MINOR-1:0] RST_MINOR_EN = 4'hF;
	localparam logic [2:0]           RST_USER_SEL = 3'h0;

endpackage

// [hdl/tmfs_sync.sv]
// three-stage input synchroniser with agreement filter
// assumes inputs arrive from pins outside the clock domain
`timescale 1ns/10ps

module tmfs_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// asynchronous side
	input  wire logic [WIDTH-1:0] din,
	// synchronous side
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;  // metastable stage, read only by stage2
	logic [WIDTH-1:0] stage2;  // second stage
	logic [WIDTH-1:0] stage3;  // third stage

	// shift chain
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit changes once the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					dout[g] <= 1'b0;
				end else if (stage2[g] == stage3[g]) begin
					dout[g] <= stage3[g];
				end
			end
		end
	endgenerate

endmodule

// [hdl/tmfs_supervisor.sv]
// test mode and self-test fault supervisor of a protection relay
// assumes one clock, an Avalon-MM master, and a non-volatile
// store outside that returns the saved test state after reset
`timescale 1ns/10ps

module tmfs_supervisor
	import tmfs_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// avalon-mm slave
	input  wire logic [7:0]           address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	// pins from outside the clock domain
	input  wire logic                 setting_access,
	input  wire logic                 comm_board_fault,
	input  wire logic [1:0]           major_fault_in,
	input  wire logic [NUM_MINOR-1:0] minor_fault_in,
	input  wire logic [NUM_OPND-1:0]  user_operand,
	input  wire logic [NUM_UNIT-1:0]  unit_responding,
	// non-volatile test state store
	input  wire logic [1:0]           nv_state_rd,
	output logic      [1:0]           nv_state_wr_data,
	output logic                      nv_state_wr,
	// field commands and field inputs, one per unit
	input  wire logic [NUM_UNIT-1:0]  contact_cmd_in,
	input  wire logic [NUM_UNIT-1:0]  latch_cmd_in,
	output logic      [NUM_UNIT-1:0]  field_contact_output_cmd,
	output logic      [NUM_UNIT-1:0]  field_latch_output_cmd,
	input  wire logic [NUM_UNIT-1:0]  field_input_raw,
	input  wire logic [NUM_UNIT-1:0]  field_input_failsafe,
	output logic      [NUM_UNIT-1:0]  field_input_operand,
	// shared outputs and shared inputs
	input  wire logic [NUM_SHARE-1:0] shared_cmd_in,
	output logic      [NUM_SHARE-1:0] shared_out,
	output logic                      shared_test_flag,
	input  wire logic [NUM_SHARE-1:0] shared_rx_data,
	input  wire logic                 shared_rx_test,
	output logic      [NUM_SHARE-1:0] shared_in_operand,
	// goose messages
	output logic                      goose_tx_test_flag,
	input  wire logic [NUM_SHARE-1:0] goose_rx_data,
	input  wire logic                 goose_rx_test,
	output logic      [NUM_SHARE-1:0] goose_operand,
	// protection operands
	input  wire logic [NUM_SHARE-1:0] prot_operand_in,
	input  wire logic [NUM_SHARE-1:0] prot_disabled_value,
	output logic      [NUM_SHARE-1:0] prot_operand_out,
	output logic                      prot_event_suppress,
	// supervision outputs
	output logic                      config_locked,
	output logic                      critical_fail_energize,
	output logic                      led_red,
	output logic                      led_orange,
	output logic                      led_flash,
	output logic      [NUM_TEST-1:0]  self_test_status,
	output logic                      any_major,
	output logic                      any_minor,
	output logic                      any_self_test,
	output logic      [NUM_TEST-1:0]  fault_record_log,
	output logic                      out_of_service_event
);

	// =========================================================
	// functions

	// map any code to a legal state, three reads as disabled
	function automatic logic [1:0] legal_state(input logic [1:0] code);
		legal_state = (code == TST_ISOLATED || code == TST_FORCIBLE) ?
			code : TST_DISABLED;
	endfunction

	// true when the state is one of the two test states
	function automatic logic in_test(input logic [1:0] code);
		in_test = (code == TST_ISOLATED) || (code == TST_FORCIBLE);
	endfunction

	// =========================================================
	// synchronised pins
	logic                 access_s;   // setting access granted
	logic                 comm_s;     // comm board fault
	logic [1:0]           major_s;    // further major faults
	logic [NUM_MINOR-1:0] minor_s;    // minor faults
	logic [NUM_OPND-1:0]  opnd_s;     // user logic operands
	logic [NUM_UNIT-1:0]  resp_s;     // field unit responding

	tmfs_sync #(.WIDTH(1)) u_sync_access (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (setting_access),
		.dout  (access_s)
	);
	tmfs_sync #(.WIDTH(3)) u_sync_major (
		.clk   (clk),
		.rst_b (rst_b),
		.din   ({comm_board_fault, major_fault_in}),
		.dout  ({comm_s, major_s})
	);
	tmfs_sync #(.WIDTH(NUM_MINOR)) u_sync_minor (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (minor_fault_in),
		.dout  (minor_s)
	);
	tmfs_sync #(.WIDTH(NUM_OPND)) u_sync_opnd (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (user_operand),
		.dout  (opnd_s)
	);
	tmfs_sync #(.WIDTH(NUM_UNIT)) u_sync_resp (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (unit_responding),
		.dout  (resp_s)
	);

	// =========================================================
	// bus handshake
	logic        bus_ack;      // high in the answering cycle
	logic        wr_take;      // write takes effect this edge
	logic        rd_take;      // read is prepared this edge
	logic        byte0;        // low byte lane enabled

	// one wait state on every access
	assign waitrequest = (read | write) & ~bus_ack;
	assign wr_take     = write & bus_ack;
	assign rd_take     = read & ~bus_ack;
	assign byte0       = byteenable[0];

	// ack toggles high for one cycle per request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (read | write) & ~bus_ack;
		end
	end

	// =========================================================
	// registers
	logic [1:0]           test_state;  // current test state
	logic                 nv_loaded;   // saved state taken after reset
	logic [NUM_TEST-1:0]  alarm_list;  // entries awaiting acknowledge
	logic [NUM_MINOR-1:0] minor_en;    // minor test enables
	logic [2:0]           user_sel;    // selected user operand
	logic [NUM_TEST-1:0]  live_prev;   // last cycle test status
	logic                 major_prev;  // last cycle major summary
	logic                 test_on;     // test flag source
	logic [NUM_TEST-1:0]  live;        // live self-test status
	logic [NUM_TEST-1:0]  ack_bits;    // acknowledge strobes

	// =========================================================
	// test state, restored once after reset then user driven
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			test_state <= TST_DISABLED;
			nv_loaded  <= 1'b0;
		end else if (!nv_loaded) begin
			// first edge after release takes the saved state
			test_state <= legal_state(nv_state_rd);
			nv_loaded  <= 1'b1;
		end else if (wr_take && address == OFS_TEST_STATE && byte0
			&& access_s) begin
			// explicit command under setting access only
			test_state <= legal_state(writedata[1:0]);
		end
	end

	// save every accepted command to the non-volatile store
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nv_state_wr      <= 1'b0;
			nv_state_wr_data <= TST_DISABLED;
		end else begin
			nv_state_wr <= nv_loaded && wr_take && byte0 && access_s
				&& address == OFS_TEST_STATE;
			if (wr_take && address == OFS_TEST_STATE && byte0 && access_s) begin
				nv_state_wr_data <= legal_state(writedata[1:0]);
			end
		end
	end

	assign test_on = in_test(test_state);

	// =========================================================
	// configuration registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			minor_en <= RST_MINOR_EN;
			user_sel <= RST_USER_SEL;
		end else if (wr_take && byte0) begin
			if (address == OFS_MINOR_EN) begin
				minor_en <= writedata[NUM_MINOR-1:0];
			end
			if (address == OFS_USER_SEL) begin
				user_sel <= writedata[2:0];
			end
		end
	end

	// =========================================================
	// self-test status operands
	always_comb begin
		live                = '0;
		live[BIT_COMM_BOARD] = comm_s;
		live[BIT_USER_SEL]   = opnd_s[user_sel];
		live[BIT_MAJOR_EXT]   = major_s[0];
		live[BIT_MAJOR_EXT+1] = major_s[1];
		// majors always report, minors gated by enables
		live[BIT_MINOR +: NUM_MINOR] = minor_s & minor_en;
	end

	assign ack_bits = (wr_take && address == OFS_ACK) ?
		writedata[NUM_TEST-1:0] : '0;

	// summaries and activation history
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			self_test_status <= '0;
			any_major        <= 1'b0;
			any_minor        <= 1'b0;
			any_self_test    <= 1'b0;
			live_prev        <= '0;
			major_prev       <= 1'b0;
		end else begin
			self_test_status <= live;
			any_major        <= |live[NUM_MAJOR-1:0];
			any_minor        <= |live[NUM_TEST-1:NUM_MAJOR];
			any_self_test    <= |live;
			live_prev        <= self_test_status;
			major_prev       <= any_major;
		end
	end

	// alarm list: set wins over acknowledge in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_list <= '0;
		end else begin
			alarm_list <= (alarm_list & ~ack_bits) | self_test_status;
		end
	end

	// one-cycle log strobes on each activation
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_record_log     <= '0;
			out_of_service_event <= 1'b0;
		end else begin
			fault_record_log     <= self_test_status & ~live_prev;
			out_of_service_event <= any_major & ~major_prev;
		end
	end

	// =========================================================
	// field, shared and protection outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			field_contact_output_cmd <= '0;
			field_latch_output_cmd   <= '0;
			field_input_operand      <= '0;
			shared_out               <= '0;
			prot_operand_out         <= '0;
			prot_event_suppress      <= 1'b0;
		end else begin
			// isolated, major fault or silent unit force commands off
			field_contact_output_cmd <= (test_state == TST_ISOLATED ||
				any_major) ? '0 : contact_cmd_in & resp_s;
			field_latch_output_cmd   <= (test_state == TST_ISOLATED ||
				any_major) ? '0 : latch_cmd_in & resp_s;
			// silent unit inputs take their failsafe value
			field_input_operand <= (field_input_raw & resp_s) |
				(field_input_failsafe & ~resp_s);
			// shared outputs run in test states, not on major fault
			shared_out <= any_major ? '0 : shared_cmd_in;
			// disabled-element values, with event logging held off
			prot_operand_out    <= any_major ? prot_disabled_value :
				prot_operand_in;
			prot_event_suppress <= any_major;
		end
	end

	// =========================================================
	// received shared and goose data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shared_in_operand <= '0;
			goose_operand     <= '0;
		end else begin
			// flagged data accepted only while this relay tests
			if (!shared_rx_test || test_on) begin
				shared_in_operand <= shared_rx_data;
			end
			// goose content used whatever its test flag
			goose_operand <= goose_rx_data;
		end
	end

	// =========================================================
	// test flags, locking, relay and indicator
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shared_test_flag       <= 1'b0;
			goose_tx_test_flag     <= 1'b0;
			config_locked          <= 1'b1;
			critical_fail_energize <= 1'b0;
			led_red                <= 1'b0;
			led_orange             <= 1'b0;
			led_flash              <= 1'b0;
		end else begin
			shared_test_flag   <= test_on;
			goose_tx_test_flag <= test_on;
			// only forcible accepts substitute field units
			config_locked <= (test_state != TST_FORCIBLE);
			// de-energized on major fault or in either test state
			critical_fail_energize <= ~any_major & ~test_on;
			case (test_state)
				TST_ISOLATED: begin
					led_red    <= 1'b1;
					led_orange <= 1'b0;
					led_flash  <= 1'b1;
				end
				TST_FORCIBLE: begin
					led_red    <= 1'b0;
					led_orange <= 1'b1;
					led_flash  <= 1'b1;
				end
				default: begin
					led_red    <= 1'b0;
					led_orange <= 1'b0;
					led_flash  <= 1'b0;
				end
			endcase
			// major fault overrides with solid red
			if (any_major) begin
				led_red    <= 1'b1;
				led_orange <= 1'b0;
				led_flash  <= 1'b0;
			end
		end
	end

	// =========================================================
	// read data, prepared in the wait cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= '0;
		end else if (rd_take) begin
			readdata <= '0;
			case (address)
				OFS_TEST_STATE: readdata[1:0] <= test_state;
				OFS_STATUS: begin
					readdata[STS_STATE +: 2] <= test_state;
					readdata[STS_FLAG]       <= shared_test_flag;
					readdata[STS_LOCK]       <= config_locked;
					readdata[STS_MAJOR]      <= any_major;
					readdata[STS_MINOR]      <= any_minor;
					readdata[STS_ANY]        <= any_self_test;
					readdata[STS_ACCESS]     <= access_s;
				end
				OFS_ALARM_LIST: readdata[NUM_TEST-1:0]  <= alarm_list;
				OFS_MINOR_EN:   readdata[NUM_MINOR-1:0] <= minor_en;
				OFS_USER_SEL:   readdata[2:0]           <= user_sel;
				OFS_TEST_LIVE:  readdata[NUM_TEST-1:0]  <= self_test_status;
				default:        readdata <= '0;
			endcase
		end
	end

	// any_major is exported so subscribers can distrust data

endmodule

// [verif/tmfs_supervisor_assertions.sv]
// ports-only checker for the test mode and fault supervisor
// bound into tmfs_supervisor from the bench top file
`timescale 1ns/10ps

module tmfs_supervisor_assertions
	import tmfs_pkg::*;
(
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_b,
	// watched signals
	input wire logic [NUM_UNIT-1:0]  field_contact_output_cmd,
	input wire logic [NUM_SHARE-1:0] shared_out,
	input wire logic                 shared_test_flag,
	input wire logic                 goose_tx_test_flag,
	input wire logic [NUM_SHARE-1:0] goose_rx_data,
	input wire logic [NUM_SHARE-1:0] goose_operand,
	input wire logic                 prot_event_suppress,
	input wire logic                 config_locked,
	input wire logic                 critical_fail_energize,
	input wire logic                 led_red,
	input wire logic                 led_flash,
	input wire logic [NUM_TEST-1:0]  self_test_status,
	input wire logic                 any_major,
	input wire logic                 any_minor,
	input wire logic                 any_self_test,
	input wire logic [NUM_TEST-1:0]  fault_record_log,
	input wire logic                 out_of_service_event
);
	// ==========================================================
	// common clocking
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// a major fault that has stood for two cycles
	sequence major_held;
		any_major && $past(any_major);
	endsequence

	// ==========================================================
	// assertions
	AST_FLAG_PAIR: assert property (shared_test_flag == goose_tx_test_flag)
		else $error("shared and goose test flags differ");
	AST_UNLOCK_FLAG: assert property (!config_locked |-> shared_test_flag)
		else $error("unlocked outside a test state");
	AST_TEST_CRIT: assert property (shared_test_flag |-> !critical_fail_energize)
		else $error("critical output energized in test state");
	AST_MAJOR_CRIT: assert property (major_held |-> !critical_fail_energize)
		else $error("critical output energized on major fault");
	AST_MAJOR_OUT: assert property (major_held |-> (field_contact_output_cmd == '0)
		&& (shared_out == '0)) else $error("outputs live on major fault");
	AST_MAJOR_LED: assert property (major_held |-> led_red && !led_flash
		&& prot_event_suppress) else $error("major fault indication wrong");
	AST_SUMMARY: assert property (any_major == |self_test_status[3:0]
		&& any_minor == |self_test_status[7:4]
		&& any_self_test == |self_test_status) else $error("summary wrong");
	AST_LOG_RISE: assert property (|(self_test_status & ~$past(self_test_status))
		|-> ##[0:1] (fault_record_log != 8'h00)) else $error("activation not logged");
	AST_OOS_EVENT: assert property ($rose(any_major) |-> ##[0:1] out_of_service_event)
		else $error("no out of service event");
	AST_GOOSE_DATA: assert property ($past(rst_b) |-> goose_operand == $past(goose_rx_data))
		else $error("goose data not taken");

	// ==========================================================
	// covers
	cover property (major_held);
	cover property (!config_locked);
	cover property (led_flash && led_red);
endmodule

// [verif/tmfs_field_model.sv]
// field units and peer relays facing the supervisor
// same clock as the supervisor; bench picks silent units
`timescale 1ns/10ps

module tmfs_field_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// bench controls
	input  wire logic [3:0] drop,
	input  wire logic       rx_flag,
	input  wire logic       peer_major,
	// toward the supervisor
	output logic      [3:0] unit_responding,
	output logic      [3:0] field_input_raw,
	output logic      [3:0] field_input_failsafe,
	output logic      [3:0] shared_rx_data,
	output logic            shared_rx_test,
	output logic      [3:0] goose_rx_data,
	output logic            goose_rx_test,
	output logic            peer_trust
);
	logic [7:0] cnt; // pattern source, moves every cycle

	// peer data never sits still, so stale holds show up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) cnt <= 8'h00;
		else cnt <= cnt + 8'h01;
	end
	assign unit_responding      = ~drop;
	assign field_input_raw      = cnt[3:0];
	assign field_input_failsafe = 4'hA;
	assign shared_rx_data       = cnt[3:0] ^ 4'h9;
	assign shared_rx_test       = rx_flag;
	assign goose_rx_data        = ~cnt[3:0];
	assign goose_rx_test        = cnt[0];
	assign peer_trust           = !peer_major;
endmodule

// [verif/tmfs_supervisor_bench.sv]
// self-checking bench for the test mode and fault supervisor
// drives the avalon bus and pins; reads compared through a queue
`timescale 1ns/10ps

module tmfs_supervisor_bench
	import tmfs_pkg::*;
;
	// ==========================================================
	// signals
	logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
	logic [7:0] address = 8'h00, user_operand = 8'h00, self_test_status, fault_record_log;
	logic [31:0] writedata = 32'h0, readdata, exp_q[$];
	logic setting_access = 1'b0, comm_board_fault = 1'b0, rx_flag = 1'b1;
	logic [1:0] major_fault_in = 2'h0, nv_state_rd = TST_ISOLATED, nv_state_wr_data, st;
	logic nv_state_wr, shared_test_flag, shared_rx_test, goose_tx_test_flag, goose_rx_test;
	logic [3:0] byteenable = 4'hF, minor_fault_in = 4'h0, drop = 4'h0, v, d;
	logic [3:0] contact_cmd_in = 4'hF, latch_cmd_in = 4'hF, shared_cmd_in = 4'h5;
	logic [3:0] prot_operand_in = 4'h3, prot_disabled_value = 4'hC, unit_responding;
	logic [3:0] field_contact_output_cmd, field_latch_output_cmd, field_input_raw;
	logic [3:0] field_input_failsafe, field_input_operand, shared_out, shared_rx_data;
	logic [3:0] shared_in_operand, goose_rx_data, goose_operand, prot_operand_out;
	logic prot_event_suppress, config_locked, critical_fail_energize, led_red, led_orange;
	logic led_flash, any_major, any_minor, any_self_test, out_of_service_event;
	int num_errors = 0, cmp_count = 0;

	always #2 clk = ~clk;

	tmfs_supervisor u_tmfs_supervisor (.*);
	tmfs_field_model u_tmfs_field_model (.*, .peer_major(any_major), .peer_trust());

	// non-volatile store keeps the last accepted state
	always @(posedge clk) if (nv_state_wr) nv_state_rd <= nv_state_wr_data;

	// ==========================================================
	// compare, verdict and bus tasks
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// watcher takes the oldest note when read data stand
	always @(posedge clk) if (read && !waitrequest) chk(exp_q.pop_front(), readdata);

	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// one request, held until waitrequest is seen low
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= dat;
		write <= w;
		read <= !w;
		do begin
			@(negedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			report_and_stop();
		end
		@(posedge clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		bus(a, 1'b1, dat);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h56B0));
		do_reset();
		rd(OFS_TEST_STATE, 32'h1);
		rd(OFS_STATUS, 32'h0D);
		cyc(1);
		chk(field_contact_output_cmd | field_latch_output_cmd, 4'h0);
		chk({led_red, led_orange, led_flash}, 3'h5);
		// no setting access: command refused
		wr(OFS_TEST_STATE, 32'h0);
		rd(OFS_TEST_STATE, 32'h1);
		setting_access <= 1'b1;
		cyc(6);
		// every state code with random commands
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			contact_cmd_in <= 4'($urandom);
			shared_cmd_in <= 4'($urandom);
			latch_cmd_in <= 4'($urandom);
			rx_flag <= (s < 3);
			wr(OFS_TEST_STATE, 32'(s));
			st = (s == 3) ? TST_DISABLED : 2'(s);
			cyc(3);
			chk({config_locked, shared_test_flag}, {st != TST_FORCIBLE, st != TST_DISABLED});
			chk(critical_fail_energize, st == TST_DISABLED);
			chk({led_orange, led_red}, {st == TST_FORCIBLE, st == TST_ISOLATED});
			chk(field_contact_output_cmd, (st == TST_ISOLATED) ? 4'h0 : contact_cmd_in);
			chk(field_latch_output_cmd, (st == TST_ISOLATED) ? 4'h0 : latch_cmd_in);
			chk(shared_out, shared_cmd_in);
			v = shared_in_operand;
			d = shared_rx_data;
			cyc(1);
			chk(shared_in_operand, (st == TST_DISABLED && rx_flag) ? v : d);
			rd(OFS_STATUS, {24'h0, 1'b1, 3'h0, st != TST_FORCIBLE, st != TST_DISABLED, st});
		end
		// byte lane 0 off: refused; unmapped reads zero
		byteenable <= 4'h0;
		wr(OFS_TEST_STATE, 32'h1);
		byteenable <= 4'hF;
		rd(OFS_TEST_STATE, 32'h0);
		rd(8'h20, 32'h0);
		// minor fault, masked, then acknowledged
		minor_fault_in <= 4'h1;
		cyc(8);
		chk({any_major, any_minor, critical_fail_energize}, 3'h3);
		rd(OFS_ALARM_LIST, 32'h10);
		wr(OFS_MINOR_EN, 32'h0);
		cyc(3);
		chk({self_test_status, any_minor}, 9'h000);
		@(posedge clk);
		minor_fault_in <= 4'h0;
		wr(OFS_MINOR_EN, 32'hF);
		wr(OFS_ACK, 32'h10);
		rd(OFS_ALARM_LIST, 32'h0);
		rd(OFS_MINOR_EN, 32'hF);
		// comm board fault takes everything down
		comm_board_fault <= 1'b1;
		cyc(8);
		chk({field_contact_output_cmd, field_latch_output_cmd, shared_out}, 12'h000);
		chk({critical_fail_energize, led_red, led_flash}, 3'h2);
		chk({prot_event_suppress, prot_operand_out}, {1'b1, prot_disabled_value});
		@(posedge clk);
		comm_board_fault <= 1'b0;
		// user-selected operand raises a major test
		wr(OFS_USER_SEL, 32'h5);
		user_operand <= 8'h20;
		cyc(8);
		chk({self_test_status, critical_fail_energize}, 9'h004);
		rd(OFS_ALARM_LIST, 32'h3);
		user_operand <= 8'h00;
		cyc(6);
		wr(OFS_ACK, 32'h3);
		rd(OFS_ALARM_LIST, 32'h0);
		rd(OFS_USER_SEL, 32'h5);
		// one field unit goes silent
		drop <= 4'h2;
		contact_cmd_in <= 4'hF;
		cyc(8);
		chk(field_contact_output_cmd, 4'hD);
		chk(field_input_operand[1], field_input_failsafe[1]);
		@(posedge clk);
		drop <= 4'h0;
		// chosen state survives a restart
		wr(OFS_TEST_STATE, 32'h2);
		do_reset();
		rd(OFS_TEST_STATE, 32'h2);
		nv_state_rd <= 2'h3;
		do_reset();
		rd(OFS_TEST_STATE, 32'h0);
		report_and_stop();
	end
endmodule

bind tmfs_supervisor tmfs_supervisor_assertions u_tmfs_supervisor_assertions (.*);
